// ---- rtl/adc_control_registers.v ----
// control and configuration logic of the 12-bit converter: registers, start
// sequencing, clock divider, channel/reference routing and pin selection.
// assumes a one-cycle register port and a converter core that returns its
// result with a done pulse; runs entirely on clk.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "adc_ctrl_defs.vh"

module adc_control_registers (
  input  wire        clk,                // system clock, 200 MHz
  input  wire        rst_n,              // asynchronous reset, active low
  input  wire [2:0]  addr,               // register byte offset
  input  wire [7:0]  wdata,              // write data
  input  wire        wr,                 // write strobe, one cycle
  input  wire        rd,                 // read strobe, one cycle
  output reg  [7:0]  rdata,              // read data, cycle after rd
  input  wire [11:0] core_result,        // raw result from converter core
  input  wire        core_done,          // core finished, one-cycle pulse
  input  wire        low_voltage_reset,  // low-voltage reset function enabled
  input  wire        low_voltage_detect, // low-voltage detect function enabled
  output reg         core_reset,         // converter held in reset
  output reg         core_start,         // launch pulse to the core
  output reg         core_power_on,      // converter powered
  output reg         conv_clk_en,        // divided converter clock tick
  output reg  [11:0] analog_inputs,      // per-input switch onto converter
  output reg         bandgap_route,      // 1.25 v onto converter input
  output reg         bandgap_power,      // bandgap circuit running
  output reg         ext_ref_select,     // reference from external pin
  output reg         ref_pin_digital_off,// external reference pin loses digital use
  output reg  [11:0] pin_analog_mode,    // pin is analog: digital and pull-high off
  output reg         conv_done_irq       // conversion end interrupt request pulse
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // software-visible fields, one register per field
  reg        start_bit;
  reg        conv_in_progress_flag;
  reg        converter_power_off;
  reg        result_justify_select;
  reg [3:0]  channel_select_field;
  reg        internal_ref_route_select;
  reg        bandgap_enable;
  reg        reference_source_select;
  reg [2:0]  conv_clock_divider;
  reg [7:0]  analog_enable_low_bits;
  reg [3:0]  analog_enable_high_bits;
  reg [7:0]  result_high_byte;
  reg [7:0]  result_low_byte;
  // divider stage counter and the marker of a conversion in flight
  reg [`DIV_CNT_W-1:0] div_cnt;
  reg        converting;

  // strobe decode; the falling step is seen on the write itself so the
  // launch is not delayed behind the start register
  wire       wr_ctrl = wr && (addr == `OFF_CONV_CONTROL);
  wire       start_fall = wr_ctrl && start_bit && !wdata[`BIT_START];
  // low bits set in the mask are the stages that must all be one for a tick;
  // seven bits wide so that the shift by six cannot overflow
  wire [6:0] div_mask = (7'h01 << conv_clock_divider) - 7'h01;
  wire [11:0] enable_all = {analog_enable_high_bits, analog_enable_low_bits};

  // ----------------------------------------------------------------
  // software-written control fields
  // ----------------------------------------------------------------
  // the progress flag is not in this process: it is read-only to software
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_bit                 <= 1'b0;
      converter_power_off       <= 1'b1;
      result_justify_select     <= 1'b0;
      channel_select_field      <= 4'h0;
      internal_ref_route_select <= 1'b0;
      bandgap_enable            <= 1'b0;
      reference_source_select   <= 1'b0;
      conv_clock_divider        <= 3'h0;
      analog_enable_low_bits    <= `RST_PIN_SEL_LOW;
      analog_enable_high_bits   <= `RST_PIN_SEL_HIGH;
    end
    else if (wr)
    begin
      case (addr)
        `OFF_CONV_CONTROL:
        begin
          start_bit             <= wdata[`BIT_START];
          converter_power_off   <= wdata[`BIT_POWER_OFF];
          result_justify_select <= wdata[`BIT_JUSTIFY];
          channel_select_field  <= wdata[3:0];
        end
        // bits 5 and 3 are not stored, so they read back as zero
        `OFF_CONV_CONFIG:
        begin
          internal_ref_route_select <= wdata[`BIT_INT_REF_ROUTE];
          bandgap_enable            <= wdata[`BIT_BANDGAP_EN];
          reference_source_select   <= wdata[`BIT_REF_SOURCE];
          conv_clock_divider        <= wdata[2:0];
        end
        `OFF_PIN_SEL_LOW:  analog_enable_low_bits  <= wdata;
        // only four pins sit above the low byte
        `OFF_PIN_SEL_HIGH: analog_enable_high_bits <= wdata[3:0];
        // writes to the result bytes and unused offsets are dropped
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  // a start written while powered off is dropped; the flag stays one
  // limitation: powering off mid-run leaves the flag at one until a later launched conversion completes
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_in_progress_flag <= 1'b1;
      converting            <= 1'b0;
      core_start            <= 1'b0;
      core_reset            <= 1'b1;
      conv_done_irq         <= 1'b0;
      result_high_byte      <= 8'h00;
      result_low_byte       <= 8'h00;
    end
    else
    begin
      core_start    <= 1'b0;
      conv_done_irq <= 1'b0;
      // write data is taken directly so reset follows the start write at once
      // start high resets
      core_reset    <= (wr_ctrl ? wdata[`BIT_START] : start_bit) || converter_power_off;
      // a start written high aborts a run and wins over a done in that cycle
      if (wr_ctrl && wdata[`BIT_START])
      begin
        conv_in_progress_flag <= 1'b1;
        converting            <= 1'b0;
      end
      else if (start_fall && !converter_power_off)
      begin
        converting            <= 1'b1;
        core_start            <= 1'b1;
        conv_in_progress_flag <= 1'b1;
      end
      else if (converting && core_done)
      begin
        converting            <= 1'b0;
        conv_in_progress_flag <= 1'b0;
        conv_done_irq         <= 1'b1;
        // the core result is only valid beside its done pulse
        // latch in the cycle the flag clears
        if (result_justify_select)
        begin
          result_high_byte <= {4'h0, core_result[11:8]};
          result_low_byte  <= core_result[7:0];
        end
        else
        begin
          result_high_byte <= core_result[11:4];
          result_low_byte  <= {core_result[3:0], 4'h0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------
  // free-running counter; the tick is the carry of the selected stage.
  // code 7 is undefined and gives no tick at all.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt     <= {`DIV_CNT_W{1'b0}};
      conv_clk_en <= 1'b0;
    end
    else
    begin
      // the counter wraps on its own; no reload is needed for any code
      div_cnt <= div_cnt + {{(`DIV_CNT_W-1){1'b0}}, 1'b1};
      if (conv_clock_divider > `DIV_CODE_LAST || converter_power_off)
        conv_clk_en <= 1'b0;
      else if (conv_clock_divider == 3'h0)
        conv_clk_en <= 1'b1;
      else
        conv_clk_en <= &(div_cnt | ~div_mask[`DIV_CNT_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // routing, reference and pin control outputs
  // ----------------------------------------------------------------
  // one flop per input and per pin; the pin mode simply mirrors its enable bit
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1)
    begin : g_route
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          analog_inputs[g]   <= 1'b0;
          pin_analog_mode[g] <= 1'b1;
        end
        else
        begin
          // codes 12 to 15 match no input; no input reaches a powered-down core
          // channel switch
          analog_inputs[g]   <= !internal_ref_route_select &&
                                (channel_select_field == g) && !converter_power_off;
          pin_analog_mode[g] <= enable_all[g];
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_power_on       <= 1'b0;
      bandgap_route       <= 1'b0;
      bandgap_power       <= 1'b0;
      ext_ref_select      <= 1'b0;
      ref_pin_digital_off <= 1'b0;
    end
    else
    begin
      // the core draws power whenever the off bit is clear, even when idle
      // power-off bit
      core_power_on       <= !converter_power_off;
      bandgap_route       <= internal_ref_route_select;
      // the low-voltage circuits share the bandgap and keep it running
      // auto bandgap off
      bandgap_power       <= (bandgap_enable && internal_ref_route_select) ||
                             low_voltage_reset || low_voltage_detect;
      // the reference pin gives up its digital use while it carries the reference
      // reference source
      ext_ref_select      <= reference_source_select;
      ref_pin_digital_off <= reference_source_select;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unimplemented bits read zero
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `OFF_CONV_CONTROL: rdata <= {start_bit, conv_in_progress_flag, converter_power_off,
                                     result_justify_select, channel_select_field};
        `OFF_CONV_CONFIG:  rdata <= {internal_ref_route_select, bandgap_enable, 1'b0,
                                     reference_source_select, 1'b0, conv_clock_divider};
        `OFF_PIN_SEL_LOW:  rdata <= analog_enable_low_bits;
        `OFF_PIN_SEL_HIGH: rdata <= {4'h0, analog_enable_high_bits};
        `OFF_RESULT_LOW:   rdata <= result_low_byte;
        `OFF_RESULT_HIGH:  rdata <= result_high_byte;
        default:           rdata <= 8'h00;
      endcase
    end
    // zero outside the answer cycle so a stale byte is never taken twice
    else
      rdata <= 8'h00;
  end

endmodule // adc_control_registers

// ---- rtl/adc_ctrl_defs.vh ----
// register offsets, field positions, reset values and codes for the converter control block
// assumes inclusion by rtl/adc_control_registers.v only
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ----------------------------------------------------------------
// register map (byte offsets on the plain register port)
// ----------------------------------------------------------------
`define OFF_CONV_CONTROL    3'h0
`define OFF_CONV_CONFIG     3'h1
`define OFF_PIN_SEL_LOW     3'h2
`define OFF_PIN_SEL_HIGH    3'h3
`define OFF_RESULT_LOW      3'h4
`define OFF_RESULT_HIGH     3'h5
`define OFF_CONV_STATUS     3'h6

// ----------------------------------------------------------------
// control and config register fields
// ----------------------------------------------------------------
`define BIT_START           7
`define BIT_IN_PROGRESS     6
`define BIT_POWER_OFF       5
`define BIT_JUSTIFY         4
`define BIT_INT_REF_ROUTE   7
`define BIT_BANDGAP_EN      6
`define BIT_REF_SOURCE      4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CONV_CONTROL    8'h60
`define RST_CONV_CONFIG     8'h00
`define RST_PIN_SEL_LOW     8'hff
`define RST_PIN_SEL_HIGH    4'hf

// ----------------------------------------------------------------
// codes and timing
// ----------------------------------------------------------------
`define CHAN_LAST_VALID     4'hb
`define DIV_CODE_LAST       3'h6
`define CONV_CLOCKS         5'h10
`define DIV_CNT_W           6

`endif

// ---- tb/adc_control_registers_asserts.sv ----
// port assertions for the converter control block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module adc_control_registers_asserts (
  input logic        clk,
  input logic        rst_n,
  input logic [2:0]  addr,
  input logic [7:0]  wdata,
  input logic        wr,
  input logic        core_done,
  input logic        low_voltage_reset,
  input logic        low_voltage_detect,
  input logic        core_reset,
  input logic        core_start,
  input logic        core_power_on,
  input logic        conv_clk_en,
  input logic [11:0] analog_inputs,
  input logic        bandgap_route,
  input logic        bandgap_power,
  input logic        ext_ref_select,
  input logic        conv_done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic start_bit;
  logic power_off;
  logic running;
  wire  ctrl_wr = wr && addr == 3'h0;
  // shadows of the start and power-off bits and of a running conversion
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_bit <= 1'b0;
      power_off <= 1'b1;
      running   <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        start_bit <= wdata[7];
        power_off <= wdata[5];
      end
      running <= core_start || (running && !core_done && !core_reset);
    end
  end
  sequence start_set_s;
    ctrl_wr && wdata[7];
  endsequence
  // the launch needs the power-off bit already clear before the falling write
  sequence start_fall_s;
    ctrl_wr && start_bit && !wdata[7] && !power_off;
  endsequence
  start_reset_a: assert property (start_set_s |=> core_reset)
    else $error("converter not held in reset while start high");
  start_hold_a: assert property (start_bit |-> core_reset)
    else $error("converter left reset while start still high");
  launch_a: assert property (start_fall_s |-> ##[1:2] core_start)
    else $error("no launch after start fell");
  launch_pulse_a: assert property (core_start |=> !core_start)
    else $error("launch pulse longer than one cycle");
  power_gate_a: assert property (!core_power_on |-> !analog_inputs && !conv_clk_en)
    else $error("converter active while powered off");
  done_irq_a: assert property (running && core_done && !core_reset &&
    !(ctrl_wr && wdata[7]) |-> ##[1:2] conv_done_irq)
    else $error("no interrupt request at conversion end");
  irq_pulse_a: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("interrupt request longer than one cycle");
  route_ext_a: assert property (bandgap_route |-> analog_inputs == 12'h000)
    else $error("external channel connected beside bandgap");
  one_hot_a: assert property ($onehot0(analog_inputs))
    else $error("more than one channel connected");
  bandgap_off_a: assert property (!bandgap_route && !low_voltage_reset &&
    !low_voltage_detect && !$past(low_voltage_reset) && !$past(low_voltage_detect)
    |-> !bandgap_power)
    else $error("bandgap running while unused");
  ext_ref_a: assert property (wr && addr == 3'h1 |->
    ##2 ext_ref_select == $past(wdata[4], 2))
    else $error("reference select does not follow register");
endmodule // adc_control_registers_asserts

// ---- tb/adc_control_registers_test.sv ----
// self-checking bench for the converter control block
// assumes the block, its checker and the core model are compiled alongside
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module adc_control_registers_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        low_voltage_reset = 1'b0;
  logic        low_voltage_detect = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic [11:0] value = 12'h000;
  logic [7:0]  rdata;
  logic [11:0] core_result, analog_inputs, pin_analog_mode;
  logic        core_done, core_reset, core_start, core_power_on, conv_clk_en;
  logic        bandgap_route, bandgap_power, ext_ref_select, ref_pin_digital_off;
  logic        conv_done_irq;
  int          n_fail = 0;
  int          tests_run = 0;
  adc_control_registers adc_control_registers_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .core_result(core_result), .core_done(core_done),
    .low_voltage_reset(low_voltage_reset), .low_voltage_detect(low_voltage_detect),
    .core_reset(core_reset), .core_start(core_start), .core_power_on(core_power_on),
    .conv_clk_en(conv_clk_en), .analog_inputs(analog_inputs),
    .bandgap_route(bandgap_route), .bandgap_power(bandgap_power),
    .ext_ref_select(ext_ref_select), .ref_pin_digital_off(ref_pin_digital_off),
    .pin_analog_mode(pin_analog_mode), .conv_done_irq(conv_done_irq));
  adc_core_model adc_core_model_i (.clk(clk), .rst_n(rst_n), .core_start(core_start),
    .core_reset(core_reset), .value(value), .delay(8'h14), .core_done(core_done),
    .core_result(core_result));
  // 200 MHz system clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_irq;
    int i;
    for (i = 0; i < 64 && conv_done_irq !== 1'b1; i++)
      cyc(1);
    if (i == 64)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic t_reset_bits;
    rchk(3'h0, 8'h60);
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'hff);
    rchk(3'h3, 8'h0f);
    rchk(3'h7, 8'h00);
    `CHK(pin_analog_mode, 12'hfff)
    wreg(3'h1, 8'hff);
    rchk(3'h1, 8'hd7);
    wreg(3'h1, 8'h00);
    wreg(3'h3, 8'hff);
    rchk(3'h3, 8'h0f);
    wreg(3'h0, 8'h1b);
    rchk(3'h0, 8'h5b);
    $display("reset and bit test done");
  endtask
  task automatic t_conv(input logic j, input logic [11:0] v);
    value <= v;
    wreg(3'h0, {3'h4, j, 4'h0});
    cyc(1);
    `CHK(core_reset, 1'b1)
    rchk(3'h0, {3'h6, j, 4'h0});
    wreg(3'h0, {3'h0, j, 4'h0});
    #1;
    `CHK(core_start, 1'b1)
    `CHK(core_reset, 1'b0)
    rchk(3'h0, {3'h2, j, 4'h0});
    wait_irq();
    cyc(1);
    `CHK(conv_done_irq, 1'b0)
    rchk(3'h0, {3'h0, j, 4'h0});
    rchk(3'h5, j ? {4'h0, v[11:8]} : v[11:4]);
    rchk(3'h4, j ? v[7:0] : {v[3:0], 4'h0});
    $display("conversion test done, justify %0d", j);
  endtask
  task automatic t_route;
    int ch;
    for (ch = 0; ch < 12; ch++)
    begin
      wreg(3'h0, ch[7:0]);
      cyc(2);
      `CHK(analog_inputs, 12'h001 << ch)
    end
    `CHK(core_power_on, 1'b1)
    // bandgap enable set before it is routed
    wreg(3'h1, 8'h40);
    cyc(8);
    wreg(3'h1, 8'hc0);
    cyc(2);
    `CHK(analog_inputs, 12'h000)
    `CHK(bandgap_route, 1'b1)
    `CHK(bandgap_power, 1'b1)
    wreg(3'h1, 8'h10);
    cyc(2);
    `CHK(analog_inputs, 12'h800)
    `CHK(bandgap_route, 1'b0)
    `CHK(bandgap_power, 1'b0)
    `CHK(ext_ref_select, 1'b1)
    `CHK(ref_pin_digital_off, 1'b1)
    @(posedge clk);
    low_voltage_detect <= 1'b1;
    cyc(2);
    `CHK(bandgap_power, 1'b1)
    @(posedge clk);
    low_voltage_detect <= 1'b0;
    low_voltage_reset  <= 1'b1;
    cyc(2);
    `CHK(bandgap_power, 1'b1)
    @(posedge clk);
    low_voltage_reset <= 1'b0;
    cyc(2);
    `CHK(bandgap_power, 1'b0)
    wreg(3'h2, 8'ha5);
    wreg(3'h3, 8'hf6);
    cyc(2);
    `CHK(pin_analog_mode, 12'h6a5)
    $display("routing test done");
  endtask
  // ticks over 128 cycles, a whole number of periods for codes 0 to 6; code 7 gives none
  task automatic t_clock;
    int code, i, n;
    for (code = 0; code < 8; code++)
    begin
      wreg(3'h1, code[7:0]);
      cyc(4);
      n = 0;
      for (i = 0; i < 128; i++)
      begin
        n += (conv_clk_en === 1'b1);
        cyc(1);
      end
      `CHK(n, code == 7 ? 0 : 128 >> code)
    end
    $display("clock divider test done");
  endtask
  task automatic t_power_off;
    wreg(3'h1, 8'h00);
    // power down before an idle spell
    wreg(3'h0, 8'h2b);
    cyc(2);
    `CHK(core_power_on, 1'b0)
    `CHK(analog_inputs, 12'h000)
    `CHK(conv_clk_en, 1'b0)
    $display("power-off test done");
  endtask
  // main sequence: reset for two cycles, then each test in turn
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_bits();
    t_conv(1'b0, 12'ha5c);
    t_conv(1'b1, 12'h3c7);
    t_route();
    t_clock();
    t_power_off();
    end_sim();
  end
endmodule // adc_control_registers_test
bind adc_control_registers adc_control_registers_asserts adc_control_registers_asserts_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .core_done(core_done),
  .low_voltage_reset(low_voltage_reset), .low_voltage_detect(low_voltage_detect),
  .core_reset(core_reset), .core_start(core_start), .core_power_on(core_power_on),
  .conv_clk_en(conv_clk_en), .analog_inputs(analog_inputs), .bandgap_route(bandgap_route),
  .bandgap_power(bandgap_power), .ext_ref_select(ext_ref_select),
  .conv_done_irq(conv_done_irq));

// ---- tb/adc_core_model.sv ----
// converter core stand-in: returns a set value after a set delay
// assumes one launch at a time from the block under test
`timescale 1ns/10ps
module adc_core_model (
  input  logic        clk,        // system clock
  input  logic        rst_n,      // reset, active low
  input  logic        core_start, // launch pulse
  input  logic        core_reset, // converter held in reset
  input  logic [11:0] value,      // result to return
  input  logic [7:0]  delay,      // launch to done, cycles
  output logic        core_done,  // done pulse
  output logic [11:0] core_result // result bus
);
  logic [7:0] cnt;
  // bus is only valid beside done, so it wanders otherwise
  assign core_result = core_done ? value : ~value ^ {4'h0, cnt};
  assign core_done   = (cnt == 8'h01);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 8'h00;
    else if (core_reset)
      cnt <= 8'h00;
    else if (core_start)
      cnt <= delay;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
endmodule // adc_core_model
